// ===== src/ssac_top.sv
// Stop-mode selection, alarm thresholds and drive commands
`default_nettype none
`include "ssac_consts.svh"
module ssac_top (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic resetn_i,
	// Parameter access port
	input wire ssac_pkg::ssac_req_t reg_req_i,
	output var ssac_pkg::ssac_rsp_t reg_rsp_o,
	// Asynchronous pins
	input wire logic limit_sw_i,
	input wire logic estop_i,
	input wire logic drive_en_i,
	// Drive-side status
	input wire ssac_pkg::ssac_sens_t sens_i,
	input wire logic [7:0] work_mode_i,
	input wire logic enc_comm_i,
	// Stop control
	output var ssac_pkg::ssac_act_t stop_act_o,
	output var logic [31:0] decel_rate_o,
	output var logic chopper_on_o,
	// Status and commands
	output var logic [15:0] err_status_o,
	output var logic [15:0] heat_reading_o,
	output var logic [1:0] motor_src_o,
	output var logic boot_req_o,
	output var logic restart_req_o,
	output var logic emu_en_o,
	output var logic [15:0] emu_counts_o
);
	//------------------------------------------------------------
	// Pin synchronisation
	//------------------------------------------------------------
	logic [2:0] pins_s;

	ssac_sync #(
		.W(3)
	) u_sync (
		.mclk_i(mclk_i),
		.resetn_i(resetn_i),
		.d_i({limit_sw_i, estop_i, drive_en_i}),
		.q_o(pins_s)
	);

	//------------------------------------------------------------
	// Register storage
	//------------------------------------------------------------
	logic [15:0] qs_sel_r, shut_sel_r, dis_sel_r, pause_sel_r, err_sel_r;
	logic [31:0] edec_r, pdec_r;
	logic [15:0] heat_thr_r, low_thr_r, chop_thr_r, high_thr_r;
	logic [15:0] restart_r, ctrl_r, emu_set_r, emu_act_r;
	logic [7:0] msrc_r;
	logic [15:0] err_r;
	logic [15:0] heat_rd;
	logic [15:0] rdv;
	logic known, wr_ok, wr_go;
	logic [15:0] a, d;

	assign a = reg_req_i.addr;
	assign d = reg_req_i.wdata;

	// Invalid codes never reach the register
	function automatic logic emu_ok(input logic [15:0] v);
		emu_ok = (v == 16'h0000) || (v == `SSAC_EMU_4K) || (v == `SSAC_EMU_8K) || (v == `SSAC_EMU_10K);
	endfunction

	//------------------------------------------------------------
	// Address decode
	//------------------------------------------------------------
	always_comb begin
		known = 1'b1;
		wr_ok = 1'b1;
		rdv = 16'h0000;
		unique case (a)
			`SSAC_A_ERRSTAT: begin
				rdv = err_r;
				wr_ok = 1'b0;
			end
			`SSAC_A_RESTART: rdv = restart_r;
			`SSAC_A_CTRL: rdv = ctrl_r;
			`SSAC_A_MSRC: begin
				rdv = {8'h00, msrc_r};
				wr_ok = (d[15:8] == 8'h00) && (d[7:0] <= `SSAC_MSRC_MAX);
			end
			`SSAC_A_EMU: begin
				rdv = emu_set_r;
				wr_ok = emu_ok(d);
			end
			`SSAC_A_EDEC_LO: rdv = edec_r[15:0];
			`SSAC_A_EDEC_HI: rdv = edec_r[31:16];
			`SSAC_A_QS: begin
				rdv = qs_sel_r;
				wr_ok = ssac_pkg::code_ok(ssac_pkg::SRC_QS, d);
			end
			`SSAC_A_SHUT: begin
				rdv = shut_sel_r;
				wr_ok = ssac_pkg::code_ok(ssac_pkg::SRC_SHUT, d);
			end
			`SSAC_A_DIS: begin
				rdv = dis_sel_r;
				wr_ok = ssac_pkg::code_ok(ssac_pkg::SRC_DIS, d);
			end
			`SSAC_A_PAUSE: begin
				rdv = pause_sel_r;
				wr_ok = ssac_pkg::code_ok(ssac_pkg::SRC_PAUSE, d);
			end
			`SSAC_A_ERRSEL: begin
				rdv = err_sel_r;
				wr_ok = ssac_pkg::code_ok(ssac_pkg::SRC_FAULT, d);
			end
			`SSAC_A_PDEC_LO: rdv = pdec_r[15:0];
			`SSAC_A_PDEC_HI: rdv = pdec_r[31:16];
			`SSAC_A_HEAT_THR: rdv = heat_thr_r;
			`SSAC_A_HEAT_RD: begin
				rdv = heat_rd;
				wr_ok = 1'b0;
			end
			`SSAC_A_LOW_THR: rdv = low_thr_r;
			`SSAC_A_CHOP_THR: rdv = chop_thr_r;
			`SSAC_A_HIGH_THR: rdv = high_thr_r;
			default: begin
				known = 1'b0;
				wr_ok = 1'b0;
			end
		endcase
	end

	assign wr_go = reg_req_i.wr && known && wr_ok;

	//------------------------------------------------------------
	// Access response
	//------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			reg_rsp_o <= '0;
		end else begin
			reg_rsp_o.ack <= reg_req_i.wr || reg_req_i.rd;
			reg_rsp_o.err <= (reg_req_i.wr && !wr_go) || (reg_req_i.rd && !known);
			reg_rsp_o.rdata <= (reg_req_i.rd && known) ? rdv : 16'h0000;
		end
	end

	//------------------------------------------------------------
	// Stop selectors
	//------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			qs_sel_r <= `SSAC_RST_SEL;
			shut_sel_r <= `SSAC_RST_SEL;
			dis_sel_r <= `SSAC_RST_SEL;
			pause_sel_r <= `SSAC_RST_PAUSE;
			err_sel_r <= `SSAC_RST_SEL;
		end else if (wr_go) begin
			if (a == `SSAC_A_QS) qs_sel_r <= d;
			if (a == `SSAC_A_SHUT) shut_sel_r <= d;
			if (a == `SSAC_A_DIS) dis_sel_r <= d;
			if (a == `SSAC_A_PAUSE) pause_sel_r <= d;
			if (a == `SSAC_A_ERRSEL) err_sel_r <= d;
		end
	end

	//------------------------------------------------------------
	// Deceleration rates and thresholds
	//------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			edec_r <= `SSAC_RST_EDEC;
			pdec_r <= `SSAC_RST_PDEC;
			heat_thr_r <= `SSAC_RST_HEAT_THR;
			low_thr_r <= `SSAC_RST_LOW_THR;
			chop_thr_r <= `SSAC_RST_CHOP_THR;
			high_thr_r <= `SSAC_RST_HIGH_THR;
		end else if (wr_go) begin
			if (a == `SSAC_A_EDEC_LO) edec_r[15:0] <= d;
			if (a == `SSAC_A_EDEC_HI) edec_r[31:16] <= d;
			if (a == `SSAC_A_PDEC_LO) pdec_r[15:0] <= d;
			if (a == `SSAC_A_PDEC_HI) pdec_r[31:16] <= d;
			if (a == `SSAC_A_HEAT_THR) heat_thr_r <= d;
			if (a == `SSAC_A_LOW_THR) low_thr_r <= d;
			if (a == `SSAC_A_CHOP_THR) chop_thr_r <= d;
			if (a == `SSAC_A_HIGH_THR) high_thr_r <= d;
		end
	end

	//------------------------------------------------------------
	// Control word, source, commands and encoder emulation
	//------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ctrl_r <= 16'h0000;
			restart_r <= 16'h0000;
			msrc_r <= `SSAC_RST_MSRC;
			emu_set_r <= 16'h0000;
		end else if (wr_go) begin
			if (a == `SSAC_A_CTRL) ctrl_r <= d;
			if (a == `SSAC_A_RESTART) restart_r <= d;
			if (a == `SSAC_A_MSRC) msrc_r <= d[7:0];
			if (a == `SSAC_A_EMU) emu_set_r <= d;
		end
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			boot_req_o <= 1'b0;
			restart_req_o <= 1'b0;
		end else begin
			boot_req_o <= wr_go && (a == `SSAC_A_RESTART) && (d == `SSAC_CMD_BOOT);
			restart_req_o <= wr_go && (a == `SSAC_A_RESTART) && (d == `SSAC_CMD_RESTART);
		end
	end

	// New resolution is taken only when the drive restarts
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			emu_act_r <= 16'h0000;
			emu_en_o <= 1'b0;
		end else if (restart_req_o) begin
			emu_act_r <= enc_comm_i ? emu_set_r : 16'h0000;
			emu_en_o <= enc_comm_i && (emu_set_r != 16'h0000);
		end
	end

	assign emu_counts_o = emu_act_r;
	assign motor_src_o = msrc_r[1:0];

	//------------------------------------------------------------
	// Alarms
	//------------------------------------------------------------
	logic ot_c, uv_c, ov_c, clr;
	logic [15:0] set_v;

	assign heat_rd = sens_i.temp_ok ? sens_i.temp : `SSAC_HEAT_ABSENT;
	assign ot_c = $signed(heat_rd) >= $signed(heat_thr_r);
	assign uv_c = sens_i.volt <= low_thr_r;
	assign ov_c = sens_i.volt >= high_thr_r;
	assign clr = wr_go && (a == `SSAC_A_CTRL) && d[`SSAC_CW_FRST_BIT];

	always_comb begin
		set_v = 16'h0000;
		set_v[`SSAC_ERR_OV_BIT] = ov_c;
		set_v[`SSAC_ERR_UV_BIT] = uv_c;
		set_v[`SSAC_ERR_OT_BIT] = ot_c;
	end

	// A new alarm wins over a clear in the same cycle
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			err_r <= 16'h0000;
			chopper_on_o <= 1'b0;
			heat_reading_o <= 16'h0000;
		end else begin
			err_r <= (clr ? 16'h0000 : err_r) | set_v;
			chopper_on_o <= sens_i.volt >= chop_thr_r;
			heat_reading_o <= heat_rd;
		end
	end

	assign err_status_o = err_r;

	//------------------------------------------------------------
	// Stop source and action
	//------------------------------------------------------------
	ssac_pkg::ssac_src_t src_c, src_r;
	ssac_pkg::ssac_act_t act_c;
	logic [15:0] code_c;
	logic qs_c;

	assign qs_c = pins_s[2] || pins_s[1] || (ctrl_r == `SSAC_CW_QS);

	always_comb begin
		if (|err_r) src_c = ssac_pkg::SRC_FAULT;
		else if (qs_c) src_c = ssac_pkg::SRC_QS;
		else if (!pins_s[0]) src_c = ssac_pkg::SRC_SHUT;
		else if (ctrl_r == `SSAC_CW_DIS) src_c = ssac_pkg::SRC_DIS;
		else if (ctrl_r[`SSAC_CW_PAUSE_BIT]) src_c = ssac_pkg::SRC_PAUSE;
		else src_c = ssac_pkg::SRC_NONE;
	end

	always_comb begin
		unique case (src_c)
			ssac_pkg::SRC_FAULT: code_c = err_sel_r;
			ssac_pkg::SRC_QS: code_c = qs_sel_r;
			ssac_pkg::SRC_SHUT: code_c = shut_sel_r;
			ssac_pkg::SRC_DIS: code_c = dis_sel_r;
			ssac_pkg::SRC_PAUSE: code_c = pause_sel_r;
			default: code_c = 16'h0000;
		endcase
	end

	ssac_halt_map u_map (
		.src_i(src_c),
		.code_i(code_c),
		.act_o(act_c)
	);

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			src_r <= ssac_pkg::SRC_NONE;
			stop_act_o <= ssac_pkg::ACT_NONE;
			decel_rate_o <= 32'h0000_0000;
		end else begin
			src_r <= src_c;
			stop_act_o <= act_c;
			unique case (act_c)
				ssac_pkg::ACT_RAMP_OFF, ssac_pkg::ACT_RAMP_STAY, ssac_pkg::ACT_CUR_RAMP:
					decel_rate_o <= ((work_mode_i == `SSAC_MODE_A) || (work_mode_i == `SSAC_MODE_B)) ?
						pdec_r : edec_r;
				ssac_pkg::ACT_QS_OFF, ssac_pkg::ACT_QS_STAY: decel_rate_o <= edec_r;
				default: decel_rate_o <= 32'h0000_0000;
			endcase
		end
	end

	//------------------------------------------------------------
	// Assertions
	//------------------------------------------------------------
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!resetn_i);

	sequence s_bad_qs_wr;
		reg_req_i.wr && (a == `SSAC_A_QS) && !ssac_pkg::code_ok(ssac_pkg::SRC_QS, d);
	endsequence

	sequence s_boot_wr;
		reg_req_i.wr && (a == `SSAC_A_RESTART) && (d == `SSAC_CMD_BOOT);
	endsequence

	quick_stop_src_a: assert property ((qs_c && !(|err_r)) |=> (src_r == ssac_pkg::SRC_QS))
		else $error("quick stop not selected");
	sel_reject_a: assert property (s_bad_qs_wr |=> $stable(qs_sel_r) ##0 reg_rsp_o.err)
		else $error("illegal selector accepted");
	winding_act_a: assert property ((src_c == ssac_pkg::SRC_FAULT) && (err_sel_r == `SSAC_CODE_WIND)
		|=> (stop_act_o == ssac_pkg::ACT_WINDING))
		else $error("winding brake not applied");
	pause_stay_a: assert property ((src_c == ssac_pkg::SRC_PAUSE) && (pause_sel_r == `SSAC_CODE_RAMP)
		|=> (stop_act_o == ssac_pkg::ACT_CUR_RAMP))
		else $error("pause not current ramp");
	qs_rate_a: assert property ((act_c == ssac_pkg::ACT_QS_OFF) |=> (decel_rate_o == $past(edec_r)))
		else $error("quick-stop rate wrong");
	profile_rate_a: assert property ((act_c == ssac_pkg::ACT_RAMP_OFF) && (work_mode_i != `SSAC_MODE_A)
		&& (work_mode_i != `SSAC_MODE_B) |=> (decel_rate_o == $past(edec_r)))
		else $error("profile rate outside modes");
	heat_alarm_a: assert property (ot_c |=> err_r[`SSAC_ERR_OT_BIT])
		else $error("over-temperature missed");
	heat_absent_a: assert property (!sens_i.temp_ok |=> (heat_reading_o == `SSAC_HEAT_ABSENT))
		else $error("absent sensor reading wrong");
	under_volt_a: assert property (uv_c |=> err_r[`SSAC_ERR_UV_BIT])
		else $error("under-voltage missed");
	over_volt_a: assert property (ov_c |=> err_r[`SSAC_ERR_OV_BIT])
		else $error("over-voltage missed");
	chopper_on_a: assert property ((sens_i.volt >= chop_thr_r) |=> chopper_on_o)
		else $error("chopper not engaged");
	alarm_hold_a: assert property ($rose(err_r[`SSAC_ERR_OT_BIT]) && !clr |=> err_r[`SSAC_ERR_OT_BIT])
		else $error("alarm flag dropped");
	boot_pulse_a: assert property (s_boot_wr |=> boot_req_o ##1 !boot_req_o)
		else $error("bootloader pulse wrong");
endmodule // ssac_top
`default_nettype wire

// ===== common/ssac_consts.svh
// Constants of the servo stop and alarm block
//------------------------------------------------------------
// Function
// - Limit, e-stop or word 000B quick-stops
// - Quick-stop codes 0,1,2,5,6 set stop style
// - Code 18 brakes by windings, encoder-independent
// - Enable withdrawn uses shutdown codes, default 0
// - Disable selector takes 0,1,2,18, default 0
// - Control bit 8 pauses, drive stays enabled
// - Pause code 1 current ramp, 2 quick-stop
// - Fault uses error selector, default 0
// - Profile rate only in modes 1 and 3
// - Quick-stop decel uses emergency rate, 61000
// - Motor temperature at threshold raises alarm
// - Missing temperature sensor reads minus forty
// - Supply at low threshold flags under-voltage
// - Chopper engages at chopper voltage, 63
// - Supply at high threshold flags over-voltage
// - Motor source codes 0,1,2, default 2
// - 55AA starts bootloader, AA55 restarts
// - Emulated increments 4000/8000/10000, 0 disables
// - Status bit 6 under-, 5 over-voltage
// - Status bit 13 motor over-temperature
//------------------------------------------------------------
`ifndef SSAC_CONSTS_SVH
`define SSAC_CONSTS_SVH

// Register word addresses
`define SSAC_A_ERRSTAT 16'h1F00
`define SSAC_A_RESTART 16'h2F00
`define SSAC_A_CTRL 16'h3100
`define SSAC_A_MSRC 16'h3110
`define SSAC_A_EMU 16'h3120
`define SSAC_A_EDEC_LO 16'h3300
`define SSAC_A_EDEC_HI 16'h3301
`define SSAC_A_QS 16'h3400
`define SSAC_A_SHUT 16'h3410
`define SSAC_A_DIS 16'h3420
`define SSAC_A_PAUSE 16'h3430
`define SSAC_A_ERRSEL 16'h3440
`define SSAC_A_PDEC_LO 16'h4C00
`define SSAC_A_PDEC_HI 16'h4C01
`define SSAC_A_HEAT_THR 16'h7180
`define SSAC_A_HEAT_RD 16'h7190
`define SSAC_A_LOW_THR 16'h8670
`define SSAC_A_CHOP_THR 16'h8680
`define SSAC_A_HIGH_THR 16'h8690

// Reset values
`define SSAC_RST_EDEC 32'h0000_EE48
`define SSAC_RST_PDEC 32'h0000_2710
`define SSAC_RST_SEL 16'h0000
`define SSAC_RST_PAUSE 16'h0001
`define SSAC_RST_HEAT_THR 16'h0064
`define SSAC_RST_LOW_THR 16'h0012
`define SSAC_RST_CHOP_THR 16'h003F
`define SSAC_RST_HIGH_THR 16'h0046
`define SSAC_RST_MSRC 8'h02
`define SSAC_HEAT_ABSENT 16'hFFD8

// Selector codes and commands
`define SSAC_CODE_COAST 16'h0000
`define SSAC_CODE_RAMP 16'h0001
`define SSAC_CODE_QSD 16'h0002
`define SSAC_CODE_PSTAY 16'h0005
`define SSAC_CODE_QSTAY 16'h0006
`define SSAC_CODE_WIND 16'h0012
`define SSAC_MSRC_MAX 8'h02
`define SSAC_CW_QS 16'h000B
`define SSAC_CW_DIS 16'h0007
`define SSAC_CW_PAUSE_BIT 8
`define SSAC_CW_FRST_BIT 7
`define SSAC_ERR_OV_BIT 5
`define SSAC_ERR_UV_BIT 6
`define SSAC_ERR_OT_BIT 13
`define SSAC_CMD_BOOT 16'h55AA
`define SSAC_CMD_RESTART 16'hAA55
`define SSAC_EMU_4K 16'h0FA0
`define SSAC_EMU_8K 16'h1F40
`define SSAC_EMU_10K 16'h2710
`define SSAC_MODE_A 8'h01
`define SSAC_MODE_B 8'h03

`endif

// ===== common/ssac_pkg.sv
// Types shared by the servo stop and alarm block
`default_nettype none
`include "ssac_consts.svh"
package ssac_pkg;
	typedef enum logic [2:0] {
		SRC_NONE = 3'b000,
		SRC_FAULT = 3'b001,
		SRC_QS = 3'b010,
		SRC_SHUT = 3'b011,
		SRC_DIS = 3'b100,
		SRC_PAUSE = 3'b101
	} ssac_src_t;
	typedef enum logic [2:0] {
		ACT_NONE = 3'b000,
		ACT_COAST = 3'b001,
		ACT_RAMP_OFF = 3'b010,
		ACT_QS_OFF = 3'b011,
		ACT_RAMP_STAY = 3'b100,
		ACT_QS_STAY = 3'b101,
		ACT_WINDING = 3'b110,
		ACT_CUR_RAMP = 3'b111
	} ssac_act_t;
	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} ssac_req_t;
	typedef struct packed {
		logic [15:0] rdata;
		logic ack;
		logic err;
	} ssac_rsp_t;
	typedef struct packed {
		logic [15:0] temp;
		logic temp_ok;
		logic [15:0] volt;
	} ssac_sens_t;

	function automatic logic code_ok(input ssac_src_t s, input logic [15:0] c);
		logic base;
		base = (c == `SSAC_CODE_COAST) || (c == `SSAC_CODE_RAMP) || (c == `SSAC_CODE_QSD) ||
			(c == `SSAC_CODE_WIND);
		unique case (s)
			SRC_QS: code_ok = base || (c == `SSAC_CODE_PSTAY) || (c == `SSAC_CODE_QSTAY);
			SRC_PAUSE: code_ok = (c == `SSAC_CODE_RAMP) || (c == `SSAC_CODE_QSD);
			default: code_ok = base;
		endcase
	endfunction
endpackage
`default_nettype wire

// ===== src/ssac_sync.sv
// Two-flop synchroniser for asynchronous pins
`default_nettype none
module ssac_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic resetn_i,
	// Pins in, synchronised levels out
	input wire logic [W-1:0] d_i,
	output var logic [W-1:0] q_o
);
	logic [W-1:0] meta_r;

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			meta_r <= '0;
			q_o <= '0;
		end else begin
			meta_r <= d_i;
			q_o <= meta_r;
		end
	end
endmodule // ssac_sync
`default_nettype wire

// ===== src/ssac_halt_map.sv
// Maps a stop source and its selector code to a stop action
`default_nettype none
`include "ssac_consts.svh"
module ssac_halt_map (
	// Stop source and its selector code
	input wire ssac_pkg::ssac_src_t src_i,
	input wire logic [15:0] code_i,
	// Resulting action
	output var ssac_pkg::ssac_act_t act_o
);
	always_comb begin
		act_o = ssac_pkg::ACT_NONE;
		if (src_i == ssac_pkg::SRC_PAUSE) begin
			act_o = (code_i == `SSAC_CODE_QSD) ? ssac_pkg::ACT_QS_STAY : ssac_pkg::ACT_CUR_RAMP;
		end else if (src_i != ssac_pkg::SRC_NONE) begin
			unique case (code_i)
				`SSAC_CODE_RAMP: act_o = ssac_pkg::ACT_RAMP_OFF;
				`SSAC_CODE_QSD: act_o = ssac_pkg::ACT_QS_OFF;
				`SSAC_CODE_PSTAY: act_o = ssac_pkg::ACT_RAMP_STAY;
				`SSAC_CODE_QSTAY: act_o = ssac_pkg::ACT_QS_STAY;
				// Winding brake needs no encoder feedback
				`SSAC_CODE_WIND: act_o = ssac_pkg::ACT_WINDING;
				default: act_o = ssac_pkg::ACT_COAST;
			endcase
		end
	end
endmodule // ssac_halt_map
`default_nettype wire

// ===== verif/ssac_host_model.sv
// Host controller model driving the parameter access port
`default_nettype none
`include "ssac_consts.svh"
module ssac_host_model (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic resetn_i,
	// Parameter access port
	output var ssac_pkg::ssac_req_t req_o,
	input wire ssac_pkg::ssac_rsp_t rsp_i
);
	timeunit 1ns;
	timeprecision 100ps;

	initial req_o = '0;

	//------------------------------------------------------------
	// Single access
	//------------------------------------------------------------
	// Strobe lives for the taking edge only; answer is read in the ack cycle
	task automatic access(input logic [15:0] a, input logic [15:0] d, input logic w,
		output logic [15:0] rdat, output logic er, output logic ak);
		@(posedge mclk_i);
		#1;
		req_o = '{addr: a, wdata: d, wr: w, rd: !w};
		@(posedge mclk_i);
		#1;
		req_o = '0;
		rdat = rsp_i.rdata;
		er = rsp_i.err;
		ak = rsp_i.ack;
	endtask

	//------------------------------------------------------------
	// Emulated resolution change
	//------------------------------------------------------------
	// New resolution only counts after a restart command
	task automatic set_emulation(input logic [15:0] counts);
		logic [15:0] r;
		logic e;
		logic k;
		access(`SSAC_A_EMU, counts, 1'b1, r, e, k);
		access(`SSAC_A_RESTART, `SSAC_CMD_RESTART, 1'b1, r, e, k);
	endtask
endmodule // ssac_host_model
`default_nettype wire

// ===== verif/ssac_top_tb.sv
// Self-checking testbench of the servo stop and alarm block
`default_nettype none
`include "ssac_consts.svh"
module ssac_top_tb;
	timeunit 1ns;
	timeprecision 100ps;

	logic mclk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic limit_sw = 1'b0;
	logic estop = 1'b0;
	logic drive_en = 1'b1;
	logic enc_comm = 1'b1;
	logic [7:0] work_mode = 8'h01;
	ssac_pkg::ssac_sens_t sens = '{temp: 16'h0019, temp_ok: 1'b1, volt: 16'h0030};
	ssac_pkg::ssac_req_t req;
	ssac_pkg::ssac_rsp_t rsp;
	ssac_pkg::ssac_act_t act;
	logic [31:0] rate;
	logic chop, boot, rst_req, emu_en;
	logic [15:0] err_st, heat, emu_cnt;
	logic [1:0] msrc;
	int fails = 0;
	int cmp_count = 0;

	always #12.5 mclk_i = ~mclk_i;

	ssac_host_model u_host (.mclk_i(mclk_i), .resetn_i(resetn_i), .req_o(req), .rsp_i(rsp));

	ssac_top u_dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .reg_req_i(req), .reg_rsp_o(rsp),
		.limit_sw_i(limit_sw), .estop_i(estop), .drive_en_i(drive_en), .sens_i(sens),
		.work_mode_i(work_mode), .enc_comm_i(enc_comm), .stop_act_o(act), .decel_rate_o(rate),
		.chopper_on_o(chop), .err_status_o(err_st), .heat_reading_o(heat), .motor_src_o(msrc),
		.boot_req_o(boot), .restart_req_o(rst_req), .emu_en_o(emu_en), .emu_counts_o(emu_cnt));

	//------------------------------------------------------------
	// Helpers
	//------------------------------------------------------------
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Longest stop path is pin sync plus core register
	task automatic settle();
		repeat (5) @(posedge mclk_i);
		#1;
	endtask

	task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic e);
		logic [15:0] r;
		logic er, ak;
		u_host.access(a, d, 1'b1, r, er, ak);
		cmp({31'h0, ak}, 32'h1);
		cmp({31'h0, er}, {31'h0, e});
	endtask

	task automatic rd(input logic [15:0] a, input logic [15:0] x, input logic e);
		logic [15:0] r;
		logic er, ak;
		u_host.access(a, 16'h0000, 1'b0, r, er, ak);
		cmp({31'h0, ak}, 32'h1);
		cmp({31'h0, er}, {31'h0, e});
		cmp({16'h0, r}, {16'h0, x});
	endtask

	task automatic chk_act(input ssac_pkg::ssac_act_t x, input logic [31:0] r, input bit with_rate);
		settle();
		cmp({29'h0, act}, {29'h0, x});
		if (with_rate)
			cmp(rate, r);
	endtask

	//------------------------------------------------------------
	// Scenarios
	//------------------------------------------------------------
	localparam logic [15:0] RA [13] = '{16'h3400, 16'h3410, 16'h3420, 16'h3430, 16'h3440, 16'h3300,
		16'h3301, 16'h4C00, 16'h7180, 16'h8670, 16'h8680, 16'h8690, 16'h3110};
	localparam logic [15:0] RV [13] = '{16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0000, 16'hEE48,
		16'h0000, 16'h2710, 16'h0064, 16'h0012, 16'h003F, 16'h0046, 16'h0002};

	task automatic s_reset();
		for (int i = 0; i < 13; i++) begin
			rd(RA[i], RV[i], 1'b0);
		end
		rd(16'h1234, 16'h0000, 1'b1);
		wr(16'h7190, 16'h0001, 1'b1);
	endtask

	localparam logic [15:0] QC [6] = '{16'h0000, 16'h0001, 16'h0002, 16'h0005, 16'h0006, 16'h0012};
	localparam ssac_pkg::ssac_act_t QA [6] = '{ssac_pkg::ACT_COAST, ssac_pkg::ACT_RAMP_OFF,
		ssac_pkg::ACT_QS_OFF, ssac_pkg::ACT_RAMP_STAY, ssac_pkg::ACT_QS_STAY, ssac_pkg::ACT_WINDING};
	localparam logic [31:0] QR [6] = '{32'h0, 32'h2710, 32'hEE48, 32'h2710, 32'hEE48, 32'h0};

	task automatic s_quick_stop();
		for (int i = 0; i < 6; i++) begin
			wr(16'h3400, QC[i], 1'b0);
			wr(16'h3100, 16'h000B, 1'b0);
			chk_act(QA[i], QR[i], 1'b1);
			wr(16'h3100, 16'h0000, 1'b0);
			chk_act(ssac_pkg::ACT_NONE, 32'h0, 1'b1);
		end
		wr(16'h3400, 16'h0001, 1'b0);
		work_mode = 8'h02;
		wr(16'h3100, 16'h000B, 1'b0);
		chk_act(ssac_pkg::ACT_RAMP_OFF, 32'hEE48, 1'b1);
		wr(16'h3100, 16'h0000, 1'b0);
		work_mode = 8'h03;
		wr(16'h3400, 16'h0002, 1'b0);
		estop = 1'b1;
		chk_act(ssac_pkg::ACT_QS_OFF, 32'hEE48, 1'b1);
		estop = 1'b0;
		limit_sw = 1'b1;
		chk_act(ssac_pkg::ACT_QS_OFF, 32'hEE48, 1'b1);
		limit_sw = 1'b0;
		chk_act(ssac_pkg::ACT_NONE, 32'h0, 1'b1);
		wr(16'h3410, 16'h0005, 1'b1);
		rd(16'h3410, 16'h0000, 1'b0);
		wr(16'h3400, 16'h0003, 1'b1);
		rd(16'h3400, 16'h0002, 1'b0);
	endtask

	task automatic s_other_stops();
		wr(16'h3410, 16'h0012, 1'b0);
		drive_en = 1'b0;
		chk_act(ssac_pkg::ACT_WINDING, 32'h0, 1'b1);
		drive_en = 1'b1;
		wr(16'h3420, 16'h0002, 1'b0);
		wr(16'h3100, 16'h0007, 1'b0);
		chk_act(ssac_pkg::ACT_QS_OFF, 32'hEE48, 1'b1);
		wr(16'h3100, 16'h0100, 1'b0);
		chk_act(ssac_pkg::ACT_CUR_RAMP, 32'h2710, 1'b1);
		wr(16'h3430, 16'h0002, 1'b0);
		chk_act(ssac_pkg::ACT_QS_STAY, 32'hEE48, 1'b1);
		wr(16'h3430, 16'h0000, 1'b1);
		wr(16'h3100, 16'h0000, 1'b0);
		chk_act(ssac_pkg::ACT_NONE, 32'h0, 1'b1);
	endtask

	localparam logic [15:0] AV [3] = '{16'h0046, 16'h0012, 16'h0030};
	localparam logic [15:0] AT [3] = '{16'h0019, 16'h0019, 16'h0064};
	localparam logic [15:0] AE [3] = '{16'h0020, 16'h0040, 16'h2000};

	task automatic s_alarms();
		wr(16'h3440, 16'h0012, 1'b0);
		sens.volt = 16'h0045;
		sens.temp = 16'h0063;
		settle();
		cmp({16'h0, err_st}, 32'h0);
		cmp({31'h0, chop}, 32'h1);
		sens.volt = 16'h003E;
		settle();
		cmp({31'h0, chop}, 32'h0);
		for (int i = 0; i < 3; i++) begin
			sens.volt = AV[i];
			sens.temp = AT[i];
			settle();
			cmp({16'h0, err_st}, {16'h0, AE[i]});
			sens.volt = 16'h0030;
			sens.temp = 16'h0019;
			chk_act(ssac_pkg::ACT_WINDING, 32'h0, 1'b1);
			cmp({16'h0, err_st}, {16'h0, AE[i]});
			wr(16'h3100, 16'h0080, 1'b0);
			wr(16'h3100, 16'h0000, 1'b0);
			chk_act(ssac_pkg::ACT_NONE, 32'h0, 1'b1);
			cmp({16'h0, err_st}, 32'h0);
		end
		wr(16'h7180, 16'h0050, 1'b0);
		sens.temp = 16'h0050;
		settle();
		cmp({16'h0, err_st}, 32'h0000_2000);
		sens.temp = 16'h0019;
		wr(16'h3100, 16'h0080, 1'b0);
		settle();
		cmp({16'h0, err_st}, 32'h0);
		sens.temp_ok = 1'b0;
		settle();
		cmp({16'h0, heat}, 32'h0000_FFD8);
		rd(16'h7190, 16'hFFD8, 1'b0);
		sens.temp_ok = 1'b1;
	endtask

	task automatic s_commands();
		wr(16'h2F00, 16'h55AA, 1'b0);
		cmp({31'h0, boot}, 32'h1);
		cmp({31'h0, rst_req}, 32'h0);
		u_host.set_emulation(16'h1F40);
		cmp({31'h0, rst_req}, 32'h1);
		settle();
		cmp({31'h0, rst_req}, 32'h0);
		cmp({31'h0, emu_en}, 32'h1);
		cmp({16'h0, emu_cnt}, 32'h0000_1F40);
		wr(16'h3120, 16'h1234, 1'b1);
		u_host.set_emulation(16'h0000);
		settle();
		cmp({31'h0, emu_en}, 32'h0);
		cmp({16'h0, emu_cnt}, 32'h0);
		enc_comm = 1'b0;
		u_host.set_emulation(16'h0FA0);
		settle();
		cmp({31'h0, emu_en}, 32'h0);
		cmp({16'h0, emu_cnt}, 32'h0);
		enc_comm = 1'b1;
		u_host.set_emulation(16'h2710);
		settle();
		cmp({31'h0, emu_en}, 32'h1);
		cmp({16'h0, emu_cnt}, 32'h0000_2710);
		wr(16'h3110, 16'h0001, 1'b0);
		settle();
		cmp({30'h0, msrc}, 32'h1);
		wr(16'h3110, 16'h0003, 1'b1);
	endtask

	//------------------------------------------------------------
	// Main sequence and watchdog
	//------------------------------------------------------------
	initial begin
		repeat (8) @(posedge mclk_i);
		#1;
		resetn_i = 1'b1;
		s_reset();
		s_quick_stop();
		s_other_stops();
		s_alarms();
		s_commands();
		final_report();
	end

	initial begin
		repeat (6000) @(posedge mclk_i);
		fails++;
		final_report();
	end
endmodule // ssac_top_tb
`default_nettype wire
